// file: hdl/tve_cfg.svh
// Constants of the trap and vector dispatch unit: offsets, trap numbers,
// flag positions and field widths.
// Assumes inclusion by the package and by the design modules.
`ifndef TVE_CFG_SVH
`define TVE_CFG_SVH

// Trap numbers
`define TVE_TN_RESET      7'h00
`define TVE_TN_SYSREQ0    7'h02
`define TVE_TN_STK_OVF    7'h04
`define TVE_TN_STK_UNF    7'h06
`define TVE_TN_SBRK       7'h08
`define TVE_TN_CLASSB     7'h0a
`define TVE_TN_NODE_FIRST 7'h68
`define TVE_TN_NODE_LAST  7'h6f
`define TVE_TN_RSV_LO     7'h0b
`define TVE_TN_RSV_HI     7'h0f
`define TVE_TN_UNASG_LO   7'h62
`define TVE_TN_UNASG_HI   7'h67

// Trap flag register layout (class B protection takes three bits)
`define TVE_FLAG_W        12
`define TVE_F_SYSREQ0     0
`define TVE_F_STK_OVF     1
`define TVE_F_STK_UNF     2
`define TVE_F_SBRK        3
`define TVE_F_SYSREQ1     4
`define TVE_F_MEMPROT_RD  5
`define TVE_F_MEMPROT_WR  6
`define TVE_F_MEMPROT_EX  7
`define TVE_F_BAD_OPCODE  8
`define TVE_F_ACC_ERR     9
`define TVE_F_PROT_FAULT  10
`define TVE_F_BAD_OPERAND 11
`define TVE_CLASSA_MASK   12'h00f
`define TVE_CLASSB_MASK   12'hff0

// Vector spacing field: spacing = 4 bytes shifted left by field
`define TVE_SPC_W         2
`define TVE_SPC_DEFAULT   2'h0
`define TVE_SPC_BASE_SH   2
`define TVE_OFS_W         12
`define TVE_SEG_W         8
`define TVE_ADDR_W        24
`define TVE_NODE_CNT      8
`define TVE_CPU_PRIO_W    4

`endif

// file: hdl/tve_pkg.sv
// Types of the trap and vector dispatch unit.
// Assumes tve_cfg.svh sits beside it on the include path.
`include "tve_cfg.svh"
package tve_pkg;
  // Dispatch state of the unit
  typedef enum logic [1:0] {
    TVE_IDLE,
    TVE_HW_TRAP,
    TVE_SW_TRAP,
    TVE_INT_SVC
  } tve_state_t;

  // Class of a hardware trap in service
  typedef enum logic [1:0] {
    TVE_CLS_NONE,
    TVE_CLS_B,
    TVE_CLS_A,
    TVE_CLS_RESET
  } tve_class_t;
endpackage

// file: hdl/tve_vector_calc.sv
// Vector address former: segment, trap number and spacing to an address.
// Assumes a purely combinational context inside the dispatch unit.
`timescale 1ns/1ps
`include "tve_cfg.svh"
module tve_vector_calc (
  // Inputs
  input  wire logic [`TVE_SEG_W-1:0]  segment,   // Vector segment register
  input  wire logic [6:0]             trap_num,  // Trap number to dispatch
  input  wire logic [`TVE_SPC_W-1:0]  spacing,   // Vector spacing field
  // Result
  output logic      [`TVE_ADDR_W-1:0] vec_addr   // Segment and offset
);
  // Offset is trap number times spacing; spacing is a power of two
  wire logic [`TVE_OFS_W-1:0] base_ofs;
  wire logic [`TVE_OFS_W-1:0] scaled_ofs;
  assign base_ofs   = {3'h0, trap_num, 2'h0};
  assign scaled_ofs = base_ofs << spacing;
  // Segment occupies the upper address byte
  assign vec_addr   = {segment, 4'h0, scaled_ofs};
endmodule // tve_vector_calc

// file: hdl/tve_trap_unit.sv
// Trap and vector dispatch unit: hardware traps, interrupt node tail,
// software traps and reset, turned into trap numbers and vector addresses.
// Assumes the CPU core acknowledges each branch request with branch_ack.
//
// Summary of operation
// - Hardware trap forces immediate non-maskable vector branch.
// - Each hardware trap sets its own flag bit.
// - Trap preempts unless an equal- or higher-priority trap is serviced or a branch request awaits its ack.
// - Trap service blocks ordinary and transfer requests.
// - Vector spacing comes from control register field.
// - Vector segment combines with in-segment offset.
// - Slots without control register stay unassigned.
// - Class A traps use own vectors 08-20.
// - Eight class B traps share vector 28.
// - System and clock nodes use numbers 68-6E.
// - End-of-transfer node uses number 6F.
`timescale 1ns/1ps
`include "tve_cfg.svh"
module tve_trap_unit (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Hardware trap conditions, one pulse per occurrence
  input  wire logic [`TVE_FLAG_W-1:0]      hw_trap_req,
  // Trap flag register: software clear by writing ones
  input  wire logic [`TVE_FLAG_W-1:0]      flag_clear,
  output logic      [`TVE_FLAG_W-1:0]      trap_flag_register,
  // Vector table configuration
  input  wire logic [`TVE_SEG_W-1:0]       vector_segment_register,
  input  wire logic [`TVE_SPC_W-1:0]       vector_spacing_field,
  // Interrupt node tail requests, bit i is trap number 68h+i
  input  wire logic [`TVE_NODE_CNT-1:0]    node_req,
  input  wire logic                        xfer_req,
  // Software trap instruction
  input  wire logic                        sw_trap_req,
  input  wire logic [6:0]                  sw_trap_num,
  input  wire logic [`TVE_CPU_PRIO_W-1:0]  cpu_prio,
  // Branch handshake with the CPU core
  output logic                             branch_req,
  output logic      [6:0]                  trap_number,
  output logic      [`TVE_ADDR_W-1:0]      vector_addr,
  output logic      [`TVE_CPU_PRIO_W-1:0]  branch_prio,
  input  wire logic                        branch_ack,
  input  wire logic                        service_done,
  // Status
  output logic                             trap_active,
  output logic                             int_blocked,
  output logic                             xfer_grant,
  output logic                             sw_trap_refused
);
  // State and service class
  tve_pkg::tve_state_t state;
  tve_pkg::tve_state_t next_state;
  tve_pkg::tve_class_t svc_class;
  tve_pkg::tve_class_t next_class;
  logic                reset_pending;  // Reset vector still to dispatch
  logic [6:0]          next_num;
  logic [`TVE_CPU_PRIO_W-1:0] next_prio;

  // Pending hardware trap causes, sticky until the flag is cleared
  logic [`TVE_FLAG_W-1:0] next_flags;
  assign next_flags = (trap_flag_register & ~flag_clear) | hw_trap_req;

  // Node request to trap number, lowest node first
  function automatic logic [6:0] node_num(input logic [`TVE_NODE_CNT-1:0] r);
    logic [6:0] n;
    n = `TVE_TN_NODE_FIRST;
    for (int i = `TVE_NODE_CNT - 1; i >= 0; i--)
      if (r[i]) n = `TVE_TN_NODE_FIRST + 7'(i);
    return n;
  endfunction

  // Reserved or unassigned slots have no control register
  function automatic logic slot_unassigned(input logic [6:0] n);
    return ((n >= `TVE_TN_RSV_LO) && (n <= `TVE_TN_RSV_HI)) ||
           ((n >= `TVE_TN_UNASG_LO) && (n <= `TVE_TN_UNASG_HI));
  endfunction

  // Class A pending picks its own vector; order sets precedence
  wire logic [`TVE_FLAG_W-1:0] pend_a;
  wire logic [`TVE_FLAG_W-1:0] pend_b;
  wire logic [6:0]             class_a_num;
  wire logic                   busy_a;
  wire logic                   new_a;
  wire logic                   new_b;
  wire logic                   node_any;
  wire logic                   sw_ok;
  assign pend_a = next_flags & `TVE_CLASSA_MASK;
  assign pend_b = next_flags & `TVE_CLASSB_MASK;
  assign class_a_num = pend_a[`TVE_F_SYSREQ0] ? `TVE_TN_SYSREQ0 :
                       pend_a[`TVE_F_STK_OVF] ? `TVE_TN_STK_OVF :
                       pend_a[`TVE_F_STK_UNF] ? `TVE_TN_STK_UNF : `TVE_TN_SBRK;
  // New causes only: a flag already standing does not retrigger
  assign new_a = |(hw_trap_req & `TVE_CLASSA_MASK);
  assign new_b = |(hw_trap_req & `TVE_CLASSB_MASK);
  assign busy_a = (svc_class == tve_pkg::TVE_CLS_A) ||
                  (svc_class == tve_pkg::TVE_CLS_RESET);
  // Interrupt nodes reach only assigned slots, never during trap service
  assign node_any = |node_req;
  assign sw_ok    = !slot_unassigned(sw_trap_num);
  assign int_blocked = (svc_class != tve_pkg::TVE_CLS_NONE);
  assign xfer_grant  = xfer_req && !int_blocked && (state == tve_pkg::TVE_IDLE);
  assign sw_trap_refused = sw_trap_req && !sw_ok;
  assign trap_active = int_blocked;

  // Dispatch decision: reset, class A, class B, software, node
  always_comb
  begin
    next_state = state;
    next_class = svc_class;
    next_num   = trap_number;
    next_prio  = branch_prio;
    if (reset_pending)
    begin
      next_state = tve_pkg::TVE_HW_TRAP;
      next_class = tve_pkg::TVE_CLS_RESET;
      next_num   = `TVE_TN_RESET;
      next_prio  = '1;
    end
    else if (branch_req)
    begin
      // Hold the request until the core takes it
      if (branch_ack)
        next_state = (state == tve_pkg::TVE_SW_TRAP) ? tve_pkg::TVE_IDLE : state;
    end
    else if (new_a && !busy_a)
    begin
      // Class A preempts anything but a class A or reset service or a branch request not yet acknowledged
      next_state = tve_pkg::TVE_HW_TRAP;
      next_class = tve_pkg::TVE_CLS_A;
      next_num   = class_a_num;
      next_prio  = '1;
    end
    else if (new_b && (svc_class == tve_pkg::TVE_CLS_NONE))
    begin
      next_state = tve_pkg::TVE_HW_TRAP;
      next_class = tve_pkg::TVE_CLS_B;
      next_num   = `TVE_TN_CLASSB;
      next_prio  = '1;
    end
    else if (service_done && (svc_class != tve_pkg::TVE_CLS_NONE))
    begin
      // Service ends; a cause still standing in its flag is not dispatched again
      next_state = tve_pkg::TVE_IDLE;
      next_class = tve_pkg::TVE_CLS_NONE;
    end
    else if (state == tve_pkg::TVE_IDLE && sw_trap_req && sw_ok)
    begin
      next_state = tve_pkg::TVE_SW_TRAP;
      next_num   = sw_trap_num;
      next_prio  = cpu_prio;
    end
    else if (state == tve_pkg::TVE_IDLE && node_any)
    begin
      next_state = tve_pkg::TVE_INT_SVC;
      next_num   = node_num(node_req);
      next_prio  = cpu_prio;
    end
    else if (state == tve_pkg::TVE_INT_SVC && service_done)
      next_state = tve_pkg::TVE_IDLE;
  end

  // Branch request rises on entry to any dispatch, drops on acknowledge
  wire logic next_branch;
  assign next_branch = reset_pending ||
                       (branch_req ? !branch_ack :
                        ((next_state != state) && (next_state != tve_pkg::TVE_IDLE)) ||
                        (next_class != svc_class && next_class != tve_pkg::TVE_CLS_NONE));

  // Vector address from segment, number and spacing
  wire logic [`TVE_ADDR_W-1:0] next_vec;
  tve_vector_calc u_calc (
    .segment  (vector_segment_register),
    .trap_num (next_num),
    .spacing  (vector_spacing_field),
    .vec_addr (next_vec)
  );

  // State registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= tve_pkg::TVE_IDLE;
      svc_class     <= tve_pkg::TVE_CLS_NONE;
      reset_pending <= 1'b1;
    end
    else
    begin
      state         <= next_state;
      svc_class     <= next_class;
      reset_pending <= 1'b0;
    end
  end

  // Output and flag registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trap_flag_register <= '0;
      branch_req         <= 1'b0;
      trap_number        <= `TVE_TN_RESET;
      vector_addr        <= '0;
      branch_prio        <= '0;
    end
    else
    begin
      trap_flag_register <= next_flags;
      branch_req         <= next_branch;
      trap_number        <= next_num;
      vector_addr        <= next_vec;
      branch_prio        <= next_prio;
    end
  end

  // A hardware cause shows in its flag on the next edge
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
      (hw_trap_req != '0) |=> ((trap_flag_register & $past(hw_trap_req)) == $past(hw_trap_req));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("trap flag not set");

  // Class B entry uses the shared number and asks for a branch
  property p_class_b;
    @(posedge clk) disable iff (!rst_n)
      (new_b && !new_a && !reset_pending && !branch_req && svc_class == tve_pkg::TVE_CLS_NONE)
      |=> (branch_req && trap_number == `TVE_TN_CLASSB);
  endproperty
  a_class_b: assert property (p_class_b) else $error("class B vector wrong");

  // Class A entry preempts lower work within one cycle
  property p_class_a;
    @(posedge clk) disable iff (!rst_n)
      (new_a && !busy_a && !reset_pending && !branch_req)
      |=> (branch_req && svc_class == tve_pkg::TVE_CLS_A);
  endproperty
  a_class_a: assert property (p_class_a) else $error("class A not taken");

  // Transfer grants never during trap service
  property p_xfer_block;
    @(posedge clk) disable iff (!rst_n)
      (svc_class != tve_pkg::TVE_CLS_NONE) |-> !xfer_grant;
  endproperty
  a_xfer_block: assert property (p_xfer_block) else $error("grant during trap");

  // First dispatch after reset is number zero
  property p_reset_vec;
    @(posedge clk) disable iff (!rst_n)
      reset_pending |=> (branch_req && trap_number == `TVE_TN_RESET);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

  // Vector address follows segment in the top byte
  property p_segment;
    @(posedge clk) disable iff (!rst_n)
      $rose(branch_req) |-> (vector_addr[`TVE_ADDR_W-1 -: `TVE_SEG_W] ==
                             $past(vector_segment_register));
  endproperty
  a_segment: assert property (p_segment) else $error("vector segment wrong");

  // Default spacing puts vector at number times four
  property p_spacing;
    @(posedge clk) disable iff (!rst_n)
      ($rose(branch_req) && $past(vector_spacing_field) == `TVE_SPC_DEFAULT)
      |-> (vector_addr[`TVE_OFS_W-1:0] == {3'h0, trap_number, 2'h0});
  endproperty
  a_spacing: assert property (p_spacing) else $error("vector spacing wrong");

  // Software trap leaves the CPU priority as it was
  property p_sw_trap;
    @(posedge clk) disable iff (!rst_n)
      (state == tve_pkg::TVE_SW_TRAP && $rose(branch_req))
      |-> (branch_prio == $past(cpu_prio));
  endproperty
  a_sw_trap: assert property (p_sw_trap) else $error("sw trap prio changed");

  // Unassigned slot never dispatched by software
  property p_unassigned;
    @(posedge clk) disable iff (!rst_n)
      (state == tve_pkg::TVE_SW_TRAP) |-> !slot_unassigned(trap_number);
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned slot used");

  // Node requests land in 68h..6Fh
  property p_node_range;
    @(posedge clk) disable iff (!rst_n)
      (state == tve_pkg::TVE_INT_SVC) |-> (trap_number >= `TVE_TN_NODE_FIRST &&
                                          trap_number <= `TVE_TN_NODE_LAST);
  endproperty
  a_node_range: assert property (p_node_range) else $error("node number out of range");
endmodule // tve_trap_unit

// file: dv/tve_core_model.sv
// CPU core model: takes branch requests of the trap unit and acknowledges
// them after a delay that the bench chooses, prompt (0) or slow.
// Assumes the bench drives its own inputs on the falling clock edge too.
`timescale 1ns/1ps
module tve_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Branch handshake
  input  wire logic       branch_req,
  input  wire logic [3:0] ack_delay,
  output logic            branch_ack
);
  logic [3:0] wait_cnt;  // Cycles spent before acknowledging

  // Ack rises off-edge and stays one rising edge only, so a held request
  // is never taken twice by the core
  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      branch_ack <= 1'b0;
      wait_cnt   <= 4'h0;
    end
    else if (branch_ack)
    begin
      branch_ack <= 1'b0;  // Taken at the rising edge just past
      wait_cnt   <= 4'h0;
    end
    else if (branch_req)
    begin
      if (wait_cnt >= ack_delay)
        branch_ack <= 1'b1;  // Core is ready to branch
      else
        wait_cnt <= wait_cnt + 4'h1;  // Slow core still busy
    end
  end
endmodule // tve_core_model

// file: dv/tve_trap_unit_test.sv
// Self-checking bench of the trap and vector dispatch unit.
// Assumes the core model sits on the branch handshake; inputs move at negedge.
`timescale 1ns/1ps
module tve_trap_unit_test;
  logic        clk, rst_n, xfer_req, sw_trap_req, service_done;
  logic [11:0] hw_trap_req, flag_clear, trap_flag_register;
  logic [7:0]  seg, node_req;
  logic [1:0]  spc;
  logic [6:0]  sw_trap_num, trap_number;
  logic [3:0]  cpu_prio, branch_prio, ack_delay;
  logic [23:0] vector_addr;
  logic        branch_req, branch_ack, trap_active, int_blocked, xfer_grant;
  logic        sw_trap_refused;
  int          err_total, n_tests;
  logic [6:0]  sw_ok[3] = '{7'h20, 7'h7f, 7'h00};  // Reachable numbers
  logic [6:0]  sw_bad[4] = '{7'h0b, 7'h0f, 7'h62, 7'h67};  // Unassigned slots

  tve_trap_unit tve_trap_unit_inst (.clk(clk), .rst_n(rst_n), .hw_trap_req(hw_trap_req),
    .flag_clear(flag_clear), .trap_flag_register(trap_flag_register),
    .vector_segment_register(seg), .vector_spacing_field(spc), .node_req(node_req),
    .xfer_req(xfer_req), .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
    .cpu_prio(cpu_prio), .branch_req(branch_req), .trap_number(trap_number),
    .vector_addr(vector_addr), .branch_prio(branch_prio), .branch_ack(branch_ack),
    .service_done(service_done), .trap_active(trap_active), .int_blocked(int_blocked),
    .xfer_grant(xfer_grant), .sw_trap_refused(sw_trap_refused));

  tve_core_model tve_core_model_inst (.clk(clk), .rst_n(rst_n), .branch_req(branch_req),
    .ack_delay(ack_delay), .branch_ack(branch_ack));

  // Free-running system clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict and end of run
  task automatic final_report;
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Case-equal compare so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Step to the next falling edge, n times
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle pulse on a hardware trap cause
  task automatic hw(input int b);
    hw_trap_req = 12'h001 << b;
    tick(1);
    hw_trap_req = 12'h000;
  endtask

  // Branch must already stand one edge after the request; then wait until the ack drops it
  task automatic take(input logic [6:0] tn);
    int i;
    check(branch_req, 1'b1);
    check(trap_number, tn);
    check(vector_addr, {seg, {9'h000, tn} << (2 + spc)});
    for (i = 0; i < 20 && branch_req === 1'b1; i++)
      tick(1);
    if (i == 20)
    begin
      err_total++;  // Core ack never ended the request
      final_report();
    end
  endtask

  // End a service and clear all flags in the same cycle
  task automatic done;
    service_done = 1'b1;
    flag_clear   = 12'hfff;
    tick(1);
    service_done = 1'b0;
    flag_clear   = 12'h000;
  endtask

  // Main sequence
  initial
  begin
    {rst_n, xfer_req, sw_trap_req, service_done, hw_trap_req, flag_clear} = '0;
    {node_req, spc, sw_trap_num, cpu_prio, ack_delay} = '0;
    seg = 8'h5a;
    err_total = 0;
    n_tests = 0;
    tick(6);
    rst_n = 1'b1;
    tick(1);
    take(7'h00);
    done();
    // Class A: own vectors, own flags, interrupts and transfers held off
    xfer_req = 1'b1;
    for (int b = 0; b < 4; b++)
    begin
      hw(b);
      take(7'h02 + 7'(2 * b));
      check(trap_flag_register, 12'h001 << b);
      check({int_blocked, trap_active, xfer_grant}, 3'b110);
      done();
      check(xfer_grant, 1'b1);
    end
    xfer_req = 1'b0;
    // Class B: one shared vector, every spacing and another segment
    for (int b = 4; b < 12; b++)
    begin
      spc = 2'(b);
      seg = 8'(8'h30 + b);
      hw(b);
      take(7'h0a);
      check(trap_flag_register, 12'h001 << b);
      done();
    end
    spc = 2'h0;
    // Node tail: consecutive numbers, last one is end of transfer
    for (int i = 0; i < 8; i++)
    begin
      node_req = 8'h01 << i;
      tick(1);
      node_req = 8'h00;
      take(7'h68 + 7'(i));
      done();
    end
    // Software traps keep the priority and touch no flag
    cpu_prio = 4'h9;
    foreach (sw_ok[k])
    begin
      sw_trap_num = sw_ok[k];
      sw_trap_req = 1'b1;
      tick(1);
      sw_trap_req = 1'b0;
      check(branch_prio, 4'h9);
      take(sw_ok[k]);
      check(trap_flag_register, 12'h000);
    end
    // Unassigned slots are refused and never dispatched
    foreach (sw_bad[k])
    begin
      sw_trap_num = sw_bad[k];
      sw_trap_req = 1'b1;
      #1;
      check(sw_trap_refused, 1'b1);
      tick(1);
      sw_trap_req = 1'b0;
      tick(1);
      check(branch_req, 1'b0);
    end
    // Slow core: class B held off during class A, class A cuts into class B
    ack_delay = 4'h5;
    hw(1);
    take(7'h04);
    hw(8);
    tick(3);
    check(branch_req, 1'b0);
    check(trap_flag_register, 12'h102);
    done();
    hw(4);
    take(7'h0a);
    hw(2);
    take(7'h06);
    done();
    done();
    // Reset wins over a trap cause present at its release
    ack_delay = 4'h0;
    hw_trap_req = 12'h001;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    hw_trap_req = 12'h000;
    take(7'h00);
    final_report();
  end
endmodule // tve_trap_unit_test
